// File: srsf_regs.svh
// constants for the receive status flag block
`ifndef SRSF_REGS_SVH
`define SRSF_REGS_SVH
`define SRSF_DATA_W 8
`define SRSF_FULL_RST 1'b0
`define SRSF_OVR_RST 1'b0
`endif

// File: srsf_pkg.sv
// types for the receive status flag block
package srsf_pkg;
  typedef enum logic [1:0] {
    SRSF_ARM_IDLE = 2'b00,
    SRSF_ARM_READ = 2'b01
  } srsf_arm_t;
endpackage : srsf_pkg

// File: srsf_clear_arm.sv
// read-then-write-0 clear qualifier for one status flag
module srsf_clear_arm (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // flag and software access
  input wire logic flag,
  input wire logic sw_read,
  input wire logic sw_write,
  input wire logic sw_wdata,
  // result
  output logic clear_ok
);
  srsf_pkg::srsf_arm_t arm_ff;
  srsf_pkg::srsf_arm_t nxt_arm;

  // a write of 0 clears only once the flag has been seen as 1
  assign clear_ok = sw_write && !sw_wdata && (arm_ff == srsf_pkg::SRSF_ARM_READ);

  always_comb begin
    nxt_arm = arm_ff;
    case (arm_ff)
      srsf_pkg::SRSF_ARM_IDLE: begin
        if (sw_read && flag) begin
          nxt_arm = srsf_pkg::SRSF_ARM_READ;
        end
      end
      srsf_pkg::SRSF_ARM_READ: begin
        // flag dropped by another cause: the old read no longer counts
        if (!flag || clear_ok) begin
          nxt_arm = srsf_pkg::SRSF_ARM_IDLE;
        end
      end
      default: begin
        nxt_arm = srsf_pkg::SRSF_ARM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      arm_ff <= srsf_pkg::SRSF_ARM_IDLE;
    end else begin
      arm_ff <= nxt_arm;
    end
  end
endmodule : srsf_clear_arm

// File: srsf_status.sv
// receive-full and overrun status flags with holding register
`include "srsf_regs.svh"

// Operation
// - receive-full flag starts at zero
// - reset or standby clears both flags
// - receive-full clears by read then write 0
// - dma read of holding register clears receive-full
// - good character sets receive-full, loads holding
// - errors keep holding, flag; receiver disable only gates rx_allow
// - character arriving while full is discarded
// - overrun flag sets when full at completion
// - overrun flag starts at zero
// - overrun clears by read then write 0
// - receiver disable leaves overrun flag alone
// - writing 1 to either flag ignored
// - overrun halts reception and sync transmission
module srsf_status #(
  parameter int DATA_W = `SRSF_DATA_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic standby,
  // receiver side
  input wire logic rx_done,
  input wire logic rx_error,
  input wire logic [DATA_W-1:0] rx_shift_data,
  input wire logic receiver_enable_bit,
  input wire logic sync_mode,
  // software access to the status flags
  input wire logic sw_read,
  input wire logic sw_write,
  input wire logic sw_wdata_full,
  input wire logic sw_wdata_ovr,
  // dma access
  input wire logic dma_read,
  // outputs
  output logic receive_full_flag,
  output logic overrun_error_flag,
  output logic [DATA_W-1:0] receive_holding_register,
  output logic rx_allow,
  output logic tx_allow
);
  // ----------------------------------------
  // flag indices
  // ----------------------------------------
  localparam int FLAG_CNT = 2;
  localparam int FLAG_FULL = 0;
  localparam int FLAG_OVR = 1;

  // ----------------------------------------
  // registered state
  // ----------------------------------------
  logic full_ff;
  logic nxt_full;
  logic ovr_ff;
  logic nxt_ovr;
  logic [DATA_W-1:0] hold_ff;
  logic [DATA_W-1:0] nxt_hold;

  // ----------------------------------------
  // clear qualifier wiring
  // ----------------------------------------
  logic [FLAG_CNT-1:0] flag_vec;
  logic [FLAG_CNT-1:0] wdata_vec;
  logic [FLAG_CNT-1:0] clr_ok_vec;

  // ----------------------------------------
  // event terms
  // ----------------------------------------
  logic full_sw_clear;
  logic ovr_sw_clear;
  logic full_dma_clear;
  logic full_clear;
  logic ovr_clear;
  logic rx_halted;
  logic char_accept;
  logic char_good;
  logic take_char;
  logic overrun_evt;
  logic sync_tx_block;
  logic sby_clear;
  logic [FLAG_CNT-1:0] set_vec;
  logic [FLAG_CNT-1:0] clr_vec;

  // ----------------------------------------
  // read-then-write-0 clear qualifiers
  // ----------------------------------------
  assign flag_vec[FLAG_FULL] = full_ff;
  assign flag_vec[FLAG_OVR] = ovr_ff;
  assign wdata_vec[FLAG_FULL] = sw_wdata_full;
  assign wdata_vec[FLAG_OVR] = sw_wdata_ovr;

  // one status read arms every flag that is set at that moment;
  // an arm drops when its flag falls by another cause, so a read taken
  // before a dma clear cannot clear a character that arrives later
  for (genvar gi = 0; gi < FLAG_CNT; gi = gi + 1) begin : g_arm
    srsf_clear_arm u_arm (
      .clock(clock),
      .rst(rst),
      .flag(flag_vec[gi]),
      .sw_read(sw_read),
      .sw_write(sw_write),
      .sw_wdata(wdata_vec[gi]),
      .clear_ok(clr_ok_vec[gi])
    );
  end

  // ----------------------------------------
  // clear events
  // ----------------------------------------
  // a write of 1 never forms a clear term, so it is simply ignored
  assign full_sw_clear = clr_ok_vec[FLAG_FULL];
  assign ovr_sw_clear = clr_ok_vec[FLAG_OVR];
  assign full_dma_clear = dma_read;
  assign full_clear = full_sw_clear || full_dma_clear;
  assign ovr_clear = ovr_sw_clear;

  // ----------------------------------------
  // receive events
  // ----------------------------------------
  // completions are dropped while overrun stands: reception is halted
  // an errored character still counts as a completion for overrun
  assign rx_halted = ovr_ff;
  assign char_accept = rx_done && !rx_halted;
  assign char_good = char_accept && !rx_error;
  assign take_char = char_good && !full_ff;
  assign overrun_evt = char_accept && full_ff;

  // ----------------------------------------
  // per-flag set and clear
  // ----------------------------------------
  assign sby_clear = standby;
  assign set_vec[FLAG_FULL] = take_char;
  assign set_vec[FLAG_OVR] = overrun_evt;
  assign clr_vec[FLAG_FULL] = full_clear;
  assign clr_vec[FLAG_OVR] = ovr_clear;

  // ----------------------------------------
  // receive-full flag
  // ----------------------------------------
  // standby beats a set, and a set beats a same-cycle clear
  always_comb begin
    if (sby_clear) begin
      nxt_full = 1'b0;
    end else if (set_vec[FLAG_FULL]) begin
      nxt_full = 1'b1;
    end else if (clr_vec[FLAG_FULL]) begin
      nxt_full = 1'b0;
    end else begin
      nxt_full = full_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      full_ff <= `SRSF_FULL_RST;
    end else begin
      full_ff <= nxt_full;
    end
  end

  // ----------------------------------------
  // overrun flag
  // ----------------------------------------
  // receiver_enable_bit deliberately plays no part here
  always_comb begin
    if (sby_clear) begin
      nxt_ovr = 1'b0;
    end else if (set_vec[FLAG_OVR]) begin
      nxt_ovr = 1'b1;
    end else if (clr_vec[FLAG_OVR]) begin
      nxt_ovr = 1'b0;
    end else begin
      nxt_ovr = ovr_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ovr_ff <= `SRSF_OVR_RST;
    end else begin
      ovr_ff <= nxt_ovr;
    end
  end

  // ----------------------------------------
  // holding register
  // ----------------------------------------
  // errored or refused characters leave the old contents in place
  always_comb begin
    if (take_char) begin
      nxt_hold = rx_shift_data;
    end else begin
      nxt_hold = hold_ff;
    end
  end

  // contents mean nothing until the full flag is set
  always_ff @(posedge clock) begin
    if (rst) begin
      hold_ff <= '0;
    end else begin
      hold_ff <= nxt_hold;
    end
  end

  // ----------------------------------------
  // receive and transmit gating
  // ----------------------------------------
  // only clocked synchronous mode stops the transmitter on overrun
  assign sync_tx_block = sync_mode && ovr_ff;
  assign rx_allow = receiver_enable_bit && !rx_halted;
  assign tx_allow = !sync_tx_block;

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign receive_full_flag = full_ff;
  assign overrun_error_flag = ovr_ff;
  assign receive_holding_register = hold_ff;
endmodule : srsf_status

// File: srsf_status_sva.sv
// flag checker for the receive status block
module srsf_status_chk #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic standby,
  // receiver side
  input wire logic rx_done,
  input wire logic rx_error,
  input wire logic [DATA_W-1:0] rx_shift_data,
  input wire logic sync_mode,
  // software and dma access
  input wire logic sw_write,
  input wire logic sw_wdata_ovr,
  input wire logic dma_read,
  // watched outputs
  input wire logic receive_full_flag,
  input wire logic overrun_error_flag,
  input wire logic [DATA_W-1:0] receive_holding_register,
  input wire logic rx_allow,
  input wire logic tx_allow
);
  wire f = receive_full_flag, o = overrun_error_flag;
  wire [DATA_W-1:0] h = receive_holding_register;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_rst_clr: assert property (disable iff (1'b0) rst |=> !f && !o) else $error("rst");
  a_sby_clr: assert property (standby |=> !f && !o) else $error("sby");
  a_rx_load: assert property (rx_done && !rx_error && !f && !o |=> h == $past(rx_shift_data))
    else $error("load");
  a_rx_ovr: assert property (rx_done && f && !o && !standby |=> o && $stable(h))
    else $error("ovr");
  a_err_keep: assert property (rx_done && rx_error |=> $stable(h)) else $error("err");
  a_dma_clr: assert property (dma_read && !rx_done |=> !f) else $error("dma");
  a_set_why: assert property ($rose(f) || $rose(o) |-> $past(rx_done)) else $error("set");
  a_ovr_fall: assert property ($fell(o) |->
    $past(rst) || $past(standby) || $past(sw_write) && !$past(sw_wdata_ovr))
    else $error("clr");
  a_wr1_keep: assert property (sw_write && !rx_done |=> !$rose(f) && !$rose(o))
    else $error("wr1");
  a_rx_halt: assert property (o |-> !rx_allow) else $error("halt");
  a_tx_halt: assert property (tx_allow == !(sync_mode && o)) else $error("tx");
endmodule : srsf_status_chk
bind srsf_status srsf_status_chk #(.DATA_W(DATA_W)) i_chk (.*);

// File: srsf_host.sv
// cpu and dma side model: strobes {read, write, wfull, wovr, dma}
module srsf_host (
  // clock
  input wire logic clock,
  // strobes towards the block
  output logic [4:0] req = 5'h00
);
  timeunit 1ns / 1ns;
  task automatic op(input logic [4:0] v);
    @(posedge clock) #1 req = v;
    @(posedge clock) #1 req = 5'h00;
  endtask : op
endmodule : srsf_host

// File: tb_srsf_status.sv
// bench for the receive status flags
module tb_srsf_status;
  timeunit 1ns / 1ns;
  logic clock = 0, rst = 1, sb = 0, dn = 0, er = 0, en = 1, sm = 1, f, o, ra, ta;
  logic [7:0] d = 8'h00, h;
  logic [4:0] q;
  wire [11:0] st = {f, o, ra, ta, h};
  int error_cnt = 0, cmp_count = 0;
  srsf_status i_srsf_status (.clock, .rst, .standby(sb), .rx_done(dn), .rx_error(er),
    .rx_shift_data(d), .receiver_enable_bit(en), .sync_mode(sm), .sw_read(q[4]),
    .sw_write(q[3]), .sw_wdata_full(q[2]), .sw_wdata_ovr(q[1]), .dma_read(q[0]),
    .receive_full_flag(f), .overrun_error_flag(o), .receive_holding_register(h),
    .rx_allow(ra), .tx_allow(ta));
  srsf_host i_srsf_host (.clock, .req(q));
  initial forever #5 clock = ~clock;
  task automatic chk(input logic [11:0] s, e);
    cmp_count++;
    if (s !== e) error_cnt++;
    if (s !== e) $display("CHECK FAILED %0t %h %h", $time, s, e);
  endtask : chk
  task automatic results();
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic rx(input logic [7:0] v, input logic e);
    @(posedge clock) #1 {dn, er, d} = {1'b1, e, v};
    @(posedge clock) #1 dn = 0;
  endtask : rx
  task automatic t_clr();
    rx(8'h77, 1);
    chk(st, 12'h300);
    rx(8'ha5, 0);
    i_srsf_host.op(5'h08);
    chk(st, 12'hba5);
    i_srsf_host.op(5'h10);
    i_srsf_host.op(5'h08);
    chk(st, 12'h3a5);
  endtask : t_clr
  task automatic t_ovr();
    rx(8'h3c, 0);
    rx(8'hc3, 0);
    en = 0;
    rx(8'h55, 0);
    chk(st, 12'hc3c);
    sm = 0;
    @(posedge clock) #1 chk(st, 12'hd3c);
    sm = 1;
    en = 1;
    i_srsf_host.op(5'h10);
    i_srsf_host.op(5'h0c);
    chk(st, 12'hb3c);
    i_srsf_host.op(5'h01);
    chk(st, 12'h33c);
    rx(8'h11, 0);
    rx(8'h22, 0);
    sb = 1;
    @(posedge clock) #1 sb = 0;
    chk(st, 12'h311);
  endtask : t_ovr
  task automatic t_arm();
    i_srsf_host.op(5'h0e);
    chk(st, 12'h311);
    rx(8'h5a, 0);
    i_srsf_host.op(5'h10);
    i_srsf_host.op(5'h01);
    rx(8'h6b, 0);
    i_srsf_host.op(5'h08);
    chk(st, 12'hb6b);
  endtask : t_arm
  task automatic t_rst();
    rx(8'h7c, 0);
    rst = 1;
    @(posedge clock) #1 rst = 0;
    chk(st, 12'h300);
    rx(8'h81, 0);
    chk(st, 12'hb81);
    fork
      rx(8'h92, 0);
      i_srsf_host.op(5'h01);
    join
    chk(st, 12'h481);
  endtask : t_rst
  initial begin
    repeat (5) @(posedge clock);
    #1 rst = 0;
    t_clr();
    t_ovr();
    t_arm();
    t_rst();
    results();
  end
endmodule : tb_srsf_status
